// file: verilog/nvmap_pkg.sv
// Package for the non-volatile memory access port.
// Assumes one bus clock; all requesters are synchronous to it.
package nvmap_pkg;

    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [5:0] OFF_ADDR_DATA   = 6'h3e;
    localparam logic [5:0] OFF_ACCESS_CTRL = 6'h3f;
    localparam int         LANE_AD         = int'(OFF_ADDR_DATA[1:0]);
    localparam int         LANE_CT         = int'(OFF_ACCESS_CTRL[1:0]);
    localparam int         CTRL_MSB        = 31;
    localparam int         CTRL_LSB        = 29;
    localparam int         AD_MSB          = 23;
    localparam int         AD_LSB          = 16;

    // Control byte values, bits 31:29
    localparam logic [2:0] CMD_OFF = 3'h0;
    localparam logic [2:0] CMD_LO  = 3'h4;
    localparam logic [2:0] CMD_HI  = 3'h5;
    localparam logic [2:0] CMD_WR  = 3'h6;
    localparam logic [2:0] CMD_RD  = 3'h7;

    // ****************************************
    // Timing, in bus clock periods; serial ack bit index and device bytes
    // ****************************************
    localparam int         SCL_DIV_DEF = 512;
    localparam logic [3:0] PAR_ON      = 4'h1;
    localparam logic [3:0] PAR_OFF     = 4'h7;
    localparam logic [3:0] PAR_SAMPLE  = 4'h6;
    localparam logic [3:0] PAR_LAST    = 4'h7;
    localparam logic [3:0] BIT_ACK     = 4'h8;
    localparam logic [7:0] SER_DEV_WR  = 8'ha0;
    localparam logic [7:0] SER_DEV_RD  = 8'ha1;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PAR  = 3'b010,
        ST_SER  = 3'b100
    } nvmap_mst_t;

    typedef enum logic [2:0] {
        K_START = 3'h0,
        K_TX    = 3'h1,
        K_RX    = 3'h2,
        K_STOP  = 3'h3,
        K_END   = 3'h4
    } nvmap_kind_t;

    typedef struct packed {
        logic        wr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } nvmap_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  dout;
        logic        doe_n;
        logic        rd_n;
        logic        wr_n;
    } nvmap_par_t;

    typedef struct packed {
        logic scl;
        logic sda_oe_n;
    } nvmap_ser_t;

    typedef struct packed {
        nvmap_mst_t  mst;
        logic [2:0]  ctrl;
        logic [7:0]  pend;
        logic [7:0]  alo;
        logic [7:0]  ahi;
        logic [7:0]  wdata;
        logic        busy;
        logic        op_rd;
        logic [15:0] op_addr;
        logic        rom_act;
        logic [1:0]  rom_cnt;
        logic [31:0] rom_data;
        logic        rom_done;
        logic [3:0]  ph;
        logic [15:0] sub;
        logic [1:0]  sq;
        logic [3:0]  step;
        logic [3:0]  bitn;
        logic [7:0]  rx;
        nvmap_par_t  par;
        nvmap_ser_t  ser;
        logic [31:0] view;
    } nvmap_state_t;

    localparam nvmap_state_t NVMAP_RST = '{
        mst:     ST_IDLE,
        par:     '{addr: 16'h0000, dout: 8'h00, doe_n: 1'b1,
                   rd_n: 1'b1, wr_n: 1'b1},
        ser:     '{scl: 1'b1, sda_oe_n: 1'b1},
        default: '0
    };

endpackage

// file: verilog/nvmap_port.sv
// Non-volatile memory access port: latches, control decode, memory engines.
// Assumes host and add-on writes arrive synchronous to clk_sys.
//
// Functional notes
// - Serial mode uses only clock and data lines
// - Byte-wide mode drives buses and both strobes
// - Host and add-on reach latches, bus-synchronous
// - Expansion ROM read does four byte reads
// - ROM window writes never change memory
// - Eight-bit data latch, three-bit control latch
// - Enable plus decode route data to latches
// - Bit 31 reads busy during C0h or E0h operation, not during ROM read
// - 80h opens low address latch
// - A0h commits low address, opens high
// - 00h commits high address, closes latches
// - C0h commits data and starts write
// - E0h commits high address, starts read
// - Data write only loads pending latch
// - Control at 3Fh, address/data at 3Eh
// - Serial clock is bus clock over 512
// - Address latches hold, never auto-increment
// - One word write loads byte and command
`timescale 1ns/10ps

module nvmap_port #(
    parameter int SCL_DIV = nvmap_pkg::SCL_DIV_DEF
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    // Host side register access
    input  wire nvmap_pkg::nvmap_req_t host_req,
    output logic [31:0]                host_rdata,
    // Add-on side register access
    input  wire nvmap_pkg::nvmap_req_t loc_req,
    output logic                       loc_ready,
    output logic [31:0]                loc_rdata,
    // Expansion ROM read
    input  wire logic                  rom_req,
    input  wire logic [15:0]           rom_addr,
    output logic [31:0]                rom_data,
    output logic                       rom_done,
    // Memory selection
    input  wire logic                  serial_mode,
    // Byte-wide memory
    output nvmap_pkg::nvmap_par_t      par,
    input  wire logic [7:0]            par_din,
    // Serial memory
    output nvmap_pkg::nvmap_ser_t      ser,
    input  wire logic                  sda_in,
    output logic                       sda_out
);

    // ****************************************
    // Constants and checks
    // ****************************************
    localparam logic [15:0] SUB_LAST = 16'(SCL_DIV / 4 - 1);
    localparam logic [15:0] HI_LAST  = 16'(SCL_DIV / 2 - 1);

    if (SCL_DIV % 4 != 0 || SCL_DIV < 8 || SCL_DIV > 131072)
    begin : g_chk
        $error("SCL_DIV must be a multiple of 4 within range");
    end

    // ****************************************
    // Serial step program
    // ****************************************
    function automatic nvmap_pkg::nvmap_kind_t ser_kind(
        input logic       rd,
        input logic [3:0] st
    );
        case (st)
            4'h0:    ser_kind = nvmap_pkg::K_START;
            4'h1,
            4'h2,
            4'h3:    ser_kind = nvmap_pkg::K_TX;
            4'h4:    ser_kind = rd ? nvmap_pkg::K_START : nvmap_pkg::K_TX;
            4'h5:    ser_kind = rd ? nvmap_pkg::K_TX : nvmap_pkg::K_STOP;
            4'h6:    ser_kind = rd ? nvmap_pkg::K_RX : nvmap_pkg::K_END;
            4'h7:    ser_kind = rd ? nvmap_pkg::K_STOP : nvmap_pkg::K_END;
            default: ser_kind = nvmap_pkg::K_END;
        endcase
    endfunction

    function automatic logic [7:0] ser_tx(
        input logic       rd,
        input logic [3:0] st,
        input logic [7:0] ah,
        input logic [7:0] al,
        input logic [7:0] wd
    );
        case (st)
            4'h1:    ser_tx = nvmap_pkg::SER_DEV_WR;
            4'h2:    ser_tx = ah;
            4'h3:    ser_tx = al;
            4'h4:    ser_tx = wd;
            4'h5:    ser_tx = nvmap_pkg::SER_DEV_RD;
            default: ser_tx = 8'hff;
        endcase
        if (!rd && st == 4'h5)
        begin
            ser_tx = 8'hff;
        end
    endfunction

    function automatic nvmap_pkg::nvmap_state_t start_op(
        input nvmap_pkg::nvmap_state_t s,
        input logic                    rd,
        input logic [15:0]             a,
        input logic                    sm
    );
        start_op          = s;
        start_op.mst      = sm ? nvmap_pkg::ST_SER : nvmap_pkg::ST_PAR;
        start_op.op_rd    = rd;
        start_op.op_addr  = a;
        start_op.ph       = 4'h0;
        start_op.sub      = 16'h0000;
        start_op.sq       = 2'h0;
        start_op.step     = 4'h0;
        start_op.bitn     = 4'h0;
        start_op.rx       = 8'h00;
        if (!sm)
        begin
            start_op.par.addr  = a;
            start_op.par.dout  = s.wdata;
            start_op.par.doe_n = rd;
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    nvmap_pkg::nvmap_state_t q;
    nvmap_pkg::nvmap_state_t d;
    nvmap_pkg::nvmap_req_t   sel;
    nvmap_pkg::nvmap_kind_t  kind;
    logic                    idle_ok;
    logic                    ad_we;
    logic                    ct_we;
    logic [2:0]              cmd_n;
    logic [7:0]              pend_n;
    logic [7:0]              txb;
    logic [3:0]              ph_n;
    logic                    strobe;
    logic                    fin;
    logic [7:0]              res;
    logic [15:0]             hi_cnt;

    always_comb
    begin
        d        = q;
        d.rom_done = 1'b0;
        fin      = 1'b0;
        res      = q.rx;
        ph_n     = q.ph + 4'h1;
        strobe   = 1'b0;
        sel      = host_req.wr ? host_req : loc_req;
        idle_ok  = (q.mst == nvmap_pkg::ST_IDLE) && !q.rom_act;
        ad_we    = sel.wr && idle_ok && sel.be[nvmap_pkg::LANE_AD];
        ct_we    = sel.wr && idle_ok && sel.be[nvmap_pkg::LANE_CT];
        cmd_n    = sel.wdata[nvmap_pkg::CTRL_MSB:nvmap_pkg::CTRL_LSB];
        pend_n   = ad_we ? sel.wdata[nvmap_pkg::AD_MSB:nvmap_pkg::AD_LSB]
                         : q.pend;
        kind     = ser_kind(q.op_rd, q.step);
        txb      = ser_tx(q.op_rd, q.step, q.ahi, q.alo, q.wdata);

        // ****************************************
        // Memory engines
        // ****************************************
        case (q.mst)
            nvmap_pkg::ST_PAR:
            begin
                if (q.ph == nvmap_pkg::PAR_LAST)
                begin
                    fin         = 1'b1;
                    d.mst       = nvmap_pkg::ST_IDLE;
                    d.par.doe_n = 1'b1;
                    d.par.rd_n  = 1'b1;
                    d.par.wr_n  = 1'b1;
                end
                else
                begin
                    d.ph       = ph_n;
                    strobe     = (ph_n >= nvmap_pkg::PAR_ON)
                                 && (ph_n < nvmap_pkg::PAR_OFF);
                    d.par.rd_n = !(strobe && q.op_rd);
                    d.par.wr_n = !(strobe && !q.op_rd);
                    if (q.ph == nvmap_pkg::PAR_SAMPLE)
                    begin
                        d.rx = par_din;
                    end
                end
            end
            nvmap_pkg::ST_SER:
            begin
                if (kind == nvmap_pkg::K_END)
                begin
                    fin   = 1'b1;
                    d.mst = nvmap_pkg::ST_IDLE;
                end
                else
                begin
                    if (q.sub == 16'h0000)
                    begin
                        d.ser.scl = (q.sq == 2'h1) || (q.sq == 2'h2)
                            || (kind == nvmap_pkg::K_STOP && q.sq == 2'h3);
                        case (kind)
                            nvmap_pkg::K_START:
                                d.ser.sda_oe_n = !q.sq[1];
                            nvmap_pkg::K_STOP:
                                d.ser.sda_oe_n = q.sq[1];
                            nvmap_pkg::K_TX:
                                if (q.sq == 2'h0)
                                begin
                                    d.ser.sda_oe_n = (q.bitn < nvmap_pkg::BIT_ACK)
                                        ? txb[3'(4'h7 - q.bitn)] : 1'b1;
                                end
                            default:
                                d.ser.sda_oe_n = 1'b1;
                        endcase
                        if (kind == nvmap_pkg::K_RX && q.sq == 2'h2
                            && q.bitn < nvmap_pkg::BIT_ACK)
                        begin
                            d.rx = {q.rx[6:0], sda_in};
                        end
                    end
                    if (q.sub == SUB_LAST)
                    begin
                        d.sub = 16'h0000;
                        d.sq  = q.sq + 2'h1;
                        if (q.sq == 2'h3)
                        begin
                            if ((kind == nvmap_pkg::K_TX
                                 || kind == nvmap_pkg::K_RX)
                                && q.bitn < nvmap_pkg::BIT_ACK)
                            begin
                                d.bitn = q.bitn + 4'h1;
                            end
                            else
                            begin
                                d.bitn = 4'h0;
                                d.step = q.step + 4'h1;
                            end
                        end
                    end
                    else
                    begin
                        d.sub = q.sub + 16'h0001;
                    end
                end
            end
            default:
            begin
            end
        endcase

        // ****************************************
        // Completion
        // ****************************************
        if (fin)
        begin
            if (q.rom_act)
            begin
                d.rom_data[{q.rom_cnt, 3'b000} +: 8] = res;
                if (q.rom_cnt == 2'h3)
                begin
                    d.rom_act  = 1'b0;
                    d.rom_done = 1'b1;
                end
                else
                begin
                    d.rom_cnt = q.rom_cnt + 2'h1;
                    d = start_op(d, 1'b1, q.op_addr + 16'h0001,
                                 serial_mode);
                end
            end
            else
            begin
                d.busy = 1'b0;
                if (q.op_rd)
                begin
                    d.pend = res;
                end
            end
        end

        // ****************************************
        // Latch writes and control decode
        // ****************************************
        if (ad_we)
        begin
            d.pend = pend_n;
        end
        if (ct_we)
        begin
            if (q.ctrl == nvmap_pkg::CMD_LO && cmd_n != q.ctrl)
            begin
                d.alo = pend_n;
            end
            if (q.ctrl == nvmap_pkg::CMD_HI && cmd_n != q.ctrl)
            begin
                d.ahi = pend_n;
            end
            d.ctrl = cmd_n;
            if (cmd_n == nvmap_pkg::CMD_WR)
            begin
                d.wdata = pend_n;
                d.busy  = 1'b1;
                d = start_op(d, 1'b0, {d.ahi, d.alo}, serial_mode);
            end
            else if (cmd_n == nvmap_pkg::CMD_RD)
            begin
                d.busy = 1'b1;
                d = start_op(d, 1'b1, {d.ahi, d.alo}, serial_mode);
            end
        end
        else if (rom_req && idle_ok && !q.busy && !q.rom_done)
        begin
            d.rom_act = 1'b1;
            d.rom_cnt = 2'h0;
            d = start_op(d, 1'b1, rom_addr, serial_mode);
        end

        d.view = {d.busy, d.ctrl[1:0], 5'h00, d.pend, 16'h0000};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            q <= nvmap_pkg::NVMAP_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign host_rdata = q.view;
    assign loc_rdata  = q.view;
    assign loc_ready  = !host_req.wr;
    assign rom_data   = q.rom_data;
    assign rom_done   = q.rom_done;
    assign par        = q.par;
    assign ser        = q.ser;
    assign sda_out    = 1'b0;

    // ****************************************
    // Checks
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (!nrst || !q.ser.scl)
        begin
            hi_cnt <= 16'h0000;
        end
        else
        begin
            hi_cnt <= hi_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_low6(sig);
        (!sig)[*6] ##1 sig;
    endsequence

    sequence s_wr_pulse;
        (!q.par.wr_n && !q.par.doe_n)[*6] ##1 (q.par.wr_n && !q.par.doe_n);
    endsequence

    property p_rd_strobe;
        $fell(q.par.rd_n) |-> s_low6(q.par.rd_n);
    endproperty
    a_rd_strobe: assert property (p_rd_strobe)
        else $error("read strobe width wrong");

    property p_wr_strobe;
        $fell(q.par.wr_n) |-> s_wr_pulse;
    endproperty
    a_wr_strobe: assert property (p_wr_strobe)
        else $error("write strobe or data hold wrong");

    property p_scl_high;
        $fell(q.ser.scl) && q.mst == nvmap_pkg::ST_SER
            && !(q.step == 4'h0 && q.sq == 2'h0)
            |-> $past(hi_cnt) == HI_LAST;
    endproperty
    a_scl_high: assert property (p_scl_high)
        else $error("serial clock high time wrong");

    property p_busy_read;
        ct_we && cmd_n == nvmap_pkg::CMD_RD
            |=> q.busy && q.op_rd && q.mst != nvmap_pkg::ST_IDLE
                && q.op_addr == {q.ahi, q.alo};
    endproperty
    a_busy_read: assert property (p_busy_read)
        else $error("read did not start");

    property p_busy_write;
        ct_we && cmd_n == nvmap_pkg::CMD_WR
            |=> q.busy && !q.op_rd && q.wdata == $past(pend_n);
    endproperty
    a_busy_write: assert property (p_busy_write)
        else $error("write did not start");

    property p_lo_commit;
        ct_we && q.ctrl == nvmap_pkg::CMD_LO && cmd_n == nvmap_pkg::CMD_HI
            |=> q.alo == $past(pend_n) && q.ctrl == nvmap_pkg::CMD_HI;
    endproperty
    a_lo_commit: assert property (p_lo_commit)
        else $error("low address not committed");

    property p_ignore_busy;
        sel.wr && q.busy |=> $stable(q.ctrl) && $stable(q.alo)
            && $stable(q.ahi) && $stable(q.wdata);
    endproperty
    a_ignore_busy: assert property (p_ignore_busy)
        else $error("write accepted while busy");

    property p_addr_hold;
        !ct_we |=> $stable(q.alo) && $stable(q.ahi);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address latch changed");

    property p_status_bit;
        host_rdata[31] == (q.mst != nvmap_pkg::ST_IDLE && !q.rom_act);
    endproperty
    a_status_bit: assert property (p_status_bit)
        else $error("status bit does not show busy");

    property p_rom_four;
        $rose(q.rom_act) && !serial_mode && $stable(serial_mode)
            |-> ##32 q.rom_done && !q.rom_act;
    endproperty
    a_rom_four: assert property (p_rom_four)
        else $error("rom read not four byte reads");

    property p_rom_no_write;
        q.rom_act |-> q.par.wr_n;
    endproperty
    a_rom_no_write: assert property (p_rom_no_write)
        else $error("memory written during rom read");

endmodule // nvmap_port

// file: testbench/nvmap_mem_model.sv
// Partner model: byte-wide memory array and serial data line pull-up.
// Assumes registered strobes from the port on clk_sys.
`timescale 1ns/10ps

module nvmap_mem_model (
    // Clock
    input  wire logic                  clk_sys,
    // Byte-wide memory pins
    input  wire nvmap_pkg::nvmap_par_t par,
    output logic [7:0]                 par_din,
    // Serial memory pins
    input  wire nvmap_pkg::nvmap_ser_t ser,
    output logic                       sda_in
);
    // ****************************************
    // Byte-wide array
    // ****************************************
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    logic       wr_n_q;

    // Released bus shows inverse of last byte
    assign par_din = par.rd_n ? ~last_q : mem[par.addr];

    // Sampled mid-cycle, where the port's strobes are settled
    always @(negedge clk_sys)
    begin
        wr_n_q <= par.wr_n;
        if (!par.rd_n)
            last_q <= par_din;
        if (!wr_n_q && par.wr_n)
            mem[par.addr] <= par.dout;
    end

    // ****************************************
    // Serial line, pull-up, acks ignored
    // ****************************************
    assign sda_in = ser.sda_oe_n ? 1'b1 : 1'b0;

endmodule // nvmap_mem_model

// file: testbench/test_nv_memory_access_port.sv
// Testbench for the memory access port with a byte-wide partner model.
// Assumes the package nvmap_pkg and the model are compiled first.
`timescale 1ns/10ps

module test_nv_memory_access_port;
    localparam int DIV = 16;
    localparam int DLY = 10;
    logic                  clk_sys;
    logic                  nrst;
    nvmap_pkg::nvmap_req_t host_req;
    nvmap_pkg::nvmap_req_t loc_req;
    logic [31:0]           host_rdata;
    logic [31:0]           loc_rdata;
    logic                  loc_ready;
    logic                  rom_req;
    logic [15:0]           rom_addr;
    logic [31:0]           rom_data;
    logic                  rom_done;
    logic                  serial_mode;
    nvmap_pkg::nvmap_par_t par;
    nvmap_pkg::nvmap_ser_t ser;
    logic [7:0]            par_din;
    logic                  sda_in;
    logic                  sda_out;
    logic [7:0]            sh [0:65535];
    int                    n_fail;
    int                    checks_done;
    int                    cyc;
    int                    seed;
    int                    nlow;
    int                    nwr;
    int                    nscl;
    realtime               t2;
    realtime               t3;
    logic [15:0]           a;

    // ****************************************
    // Clock, instances, monitors
    // ****************************************
    always #50 clk_sys = ~clk_sys;

    nvmap_port #(.SCL_DIV(DIV)) i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .host_req(host_req),
        .host_rdata(host_rdata), .loc_req(loc_req),
        .loc_ready(loc_ready), .loc_rdata(loc_rdata),
        .rom_req(rom_req), .rom_addr(rom_addr), .rom_data(rom_data),
        .rom_done(rom_done), .serial_mode(serial_mode), .par(par),
        .par_din(par_din), .ser(ser), .sda_in(sda_in), .sda_out(sda_out)
    );

    nvmap_mem_model i_mem (
        .clk_sys(clk_sys), .par(par), .par_din(par_din),
        .ser(ser), .sda_in(sda_in)
    );

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_fail++;
            end_sim();
        end
    end

    // Strobe counted mid-cycle, away from the launching edge
    always @(negedge clk_sys)
    begin
        if (par.rd_n === 1'b0)
            nlow++;
    end

    always @(negedge par.wr_n)
        nwr++;

    always @(posedge ser.scl)
    begin
        nscl++;
        if (nscl == 2)
            t2 = $realtime;
        if (nscl == 3)
            t3 = $realtime;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic put(input logic s, input logic [3:0] be,
                       input logic [31:0] w);
        if (s)
            loc_req = '{wr: 1'b1, be: be, wdata: w};
        else
            host_req = '{wr: 1'b1, be: be, wdata: w};
        @(posedge clk_sys);
        #DLY;
        host_req.wr = 1'b0;
        loc_req.wr = 1'b0;
        @(posedge clk_sys);
        #DLY;
    endtask

    task automatic ctl(input logic s, input logic [7:0] c);
        put(s, 4'h8, {c, 24'h0000_00});
    endtask

    task automatic ad(input logic s, input logic [7:0] b);
        put(s, 4'h4, {8'h00, b, 16'h0000});
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (host_rdata[31] !== 1'b0 && n < 2000)
        begin
            @(posedge clk_sys);
            #DLY;
            n++;
        end
        chk(host_rdata[31], 1'b0);
    endtask

    task automatic nv_write(input logic s, input logic [15:0] a,
                            input logic [7:0] d);
        ctl(s, 8'h80);
        ad(s, a[7:0]);
        ctl(s, 8'ha0);
        ad(s, a[15:8]);
        ctl(s, 8'h00);
        ad(s, d);
        ctl(s, 8'hc0);
        chk(host_rdata[31], 1'b1);
        wait_idle();
        sh[a] = d;
    endtask

    task automatic nv_read(input logic s, input logic [15:0] a);
        ctl(s, 8'h80);
        ad(s, ~a[7:0]);
        ad(s, a[7:0]);
        ctl(s, 8'ha0);
        ad(s, a[15:8]);
        ctl(s, 8'he0);
        chk(host_rdata[31], 1'b1);
        ad(s, 8'($random(seed)));
        ctl(s, 8'h80);
        wait_idle();
        chk(host_rdata[30:29], 2'b11);
        chk(host_rdata[23:16], sh[a]);
        chk(loc_rdata[23:16], sh[a]);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {clk_sys, nrst, rom_req, serial_mode} = '0;
        {n_fail, checks_done, cyc, nlow, nwr, nscl} = '0;
        host_req = '0;
        loc_req = '0;
        rom_addr = 16'h0000;
        seed = 69;
        repeat (6) @(posedge clk_sys);
        #DLY;
        nrst = 1'b1;
        chk(host_rdata, 32'h0000_0000);
        chk({par.rd_n, par.wr_n, ser.scl}, 3'h7);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            a = 16'($random(seed));
            nv_write(i[0], a, 8'($random(seed)));
            nv_read(~i[0], a);
        end
        $display("test random access done");
        a = a + 16'h0001;
        put(1'b0, 4'hc, {8'h80, a[7:0], 16'h0000});
        nv_write(1'b0, a, 8'h5a);
        put(1'b0, 4'hc, {8'h80, a[7:0], 16'h0000});
        ctl(1'b0, 8'ha0);
        put(1'b0, 4'hc, {8'he0, a[15:8], 16'h0000});
        wait_idle();
        chk(host_rdata[23:16], 8'h5a);
        host_req = '{wr: 1'b1, be: 4'h4, wdata: 32'h0011_0000};
        loc_req = '{wr: 1'b1, be: 4'h4, wdata: 32'h0022_0000};
        #1;
        chk(loc_ready, 1'b0);
        @(posedge clk_sys);
        #DLY;
        host_req.wr = 1'b0;
        #1;
        chk(loc_ready, 1'b1);
        chk(host_rdata[23:16], 8'h11);
        @(posedge clk_sys);
        #DLY;
        loc_req.wr = 1'b0;
        chk(host_rdata[23:16], 8'h22);
        $display("test word and arbitration done");
        for (int i = 0; i < 4; i++)
            nv_write(1'b0, 16'h1230 + 16'(i), 8'($random(seed)));
        nlow = 0;
        rom_addr = 16'h1230;
        rom_req = 1'b1;
        while (rom_done !== 1'b1 && cyc < 29000)
        begin
            @(posedge clk_sys);
            #DLY;
        end
        chk(rom_data, {sh[16'h1233], sh[16'h1232],
                       sh[16'h1231], sh[16'h1230]});
        chk(nlow, 24);
        rom_req = 1'b0;
        $display("test rom fetch done");
        serial_mode = 1'b1;
        nwr = 0;
        nscl = 0;
        nv_write(1'b0, 16'h0041, 8'hc3);
        chk(nwr, 0);
        chk(nscl > 2, 1'b1);
        chk(int'((t3 - t2) / 100.0), DIV);
        chk(ser.scl, 1'b1);
        chk(sda_out, 1'b0);
        ctl(1'b0, 8'he0);
        chk(host_rdata[31], 1'b1);
        wait_idle();
        chk(host_rdata[23:16], 8'hff);
        $display("test serial done");
        end_sim();
    end

endmodule // test_nv_memory_access_port
